// >>> design/vso_link_if.sv
// pins between the motion controller and the valve, with pull-ups resolved
`timescale 1ns/100ps
interface vso_link_if;
    logic step_drv;
    logic step_oe;
    logic dir_drv;
    logic dir_oe;
    logic close_oe;
    logic open_oe;
    logic host_tx_line;
    logic host_tx_oe;
    logic dev_tx;
    logic dev_tx_oe;
    logic step_n;
    logic dir;
    logic close_n;
    logic full_open_override_n;
    logic line;
    // undriven inputs float high through the pull-ups
    assign step_n = step_oe ? step_drv : 1'b1;
    assign dir = dir_oe ? dir_drv : 1'b1;
    assign close_n = ~close_oe;
    assign full_open_override_n = ~open_oe;
    assign line = host_tx_oe ? host_tx_line : (dev_tx_oe ? dev_tx : 1'b1);
    modport device (input step_n, input dir, input close_n, input full_open_override_n, input line,
        output dev_tx, output dev_tx_oe);
    modport host (input line, output step_drv, output step_oe, output dir_drv, output dir_oe,
        output close_oe, output open_oe, output host_tx_line, output host_tx_oe);
endinterface

// >>> design/vso_pkg.sv
// constants shared by both ends of the valve step and override link
package vso_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_DEF = 9600;
    localparam int BAUD_CYC = CLK_HZ / BAUD_DEF;
    localparam int HALF_BAUD_CYC = BAUD_CYC / 2;
    localparam int FRAME_BITS = 10;
    localparam int POWERUP_CLOSE_MS = 2000;
    localparam int POWERUP_DEF_CYC = (CLK_HZ / 1000) * POWERUP_CLOSE_MS;
    localparam int FULL_OPEN_STEPS = 25500;
    localparam int OVR_STEP_HZ = 15868;
    localparam int OVR_STEP_CYC = CLK_HZ / OVR_STEP_HZ;
    localparam int STEP_LOW_NS = 1000;
    localparam int STEP_LOW_CYC = (STEP_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // ------------------------------------------------------------
    // control modes and direction
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ANALOG = 2'h0,
        MODE_SERIAL = 2'h1,
        MODE_DIR_SPEED = 2'h2,
        MODE_STEP_DIR = 2'h3
    } vso_mode_t;
    localparam vso_mode_t MODE_RESET = MODE_STEP_DIR;
    localparam logic DIR_CLOSE = 1'b0;
    localparam logic DIR_OPEN = 1'b1;
    // ------------------------------------------------------------
    // serial register map of the valve
    // ------------------------------------------------------------
    localparam int CMD_WRITE_BIT = 7;
    localparam logic [2:0] SREG_MODE = 3'h0;
    localparam logic [2:0] SREG_POS_LO = 3'h1;
    localparam logic [2:0] SREG_POS_HI = 3'h2;
    localparam logic [2:0] SREG_STATUS = 3'h3;
    localparam int ST_CLOSE_BIT = 0;
    localparam int ST_OPEN_BIT = 1;
    localparam int ST_POWERUP_BIT = 2;
    // ------------------------------------------------------------
    // apb map of the host controller
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STEP = 8'h04;
    localparam logic [7:0] A_TXDATA = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0c;
    localparam logic [7:0] A_RXDATA = 8'h10;
    localparam int CTRL_DIR_BIT = 0;
    localparam int CTRL_CLOSE_BIT = 1;
    localparam int CTRL_OPEN_BIT = 2;
    localparam int CTRL_DRIVE_BIT = 3;
    localparam int STAT_TX_BUSY_BIT = 0;
    localparam int STAT_RX_VALID_BIT = 1;
    localparam int STAT_STEP_BUSY_BIT = 2;
    localparam logic [3:0] CTRL_RESET = 4'h0;
endpackage

// >>> design/vso_valve_dev.sv
// valve end: step gating, overrides, power-up close and serial register access
//
// What this block does
// - one step per falling step edge
// - direction sampled with the step edge
// - step input ignored outside step mode
// - floating step input reads high, no motion
// - mode set by button or serial link
// - overrides force fully closed or fully open
// - host pulls close override low to assert
// - host pulls open override low to assert
// - led green when closed under the close override, red when fully open under the open override
// - 8N1 frames at 9600 baud
// - half duplex, one talker at once
// - host drives line only while sending
// - serial access to settings and position
// - hold position when no motion commanded
// - close after power-up, then follow mode
// - direction low closes, high opens
// - each step is one microstep
`timescale 1ns/100ps
module vso_valve_dev
    import vso_pkg::*;
#(
    parameter int POWERUP_CYC = POWERUP_DEF_CYC
)
(
    input wire logic clock_i,
    input wire logic reset_i,
    vso_link_if.device link,
    input wire logic [1:0] button_mode_i,
    input wire logic button_set_i,
    output logic motor_step_o,
    output logic motor_dir_o,
    output logic motor_enable_o,
    output logic led_green_o,
    output logic led_red_o,
    output logic [1:0] mode_o,
    output logic [15:0] position_o
);
    typedef enum logic [1:0] {ST_POWERUP = 2'b01, ST_RUN = 2'b10} vso_dev_state_t;
    typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100,
        RX_STOP = 4'b1000} vso_rx_state_t;
    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} vso_tx_state_t;

    vso_dev_state_t state_q;
    vso_rx_state_t rx_q;
    vso_tx_state_t tx_q;
    vso_mode_t mode_q;
    logic step_s1_q, step_s2_q, step_s3_q, dir_s1_q, dir_s2_q;
    logic [31:0] pwr_cnt_q;
    logic [15:0] tick_cnt_q, pos_q, rx_cnt_q, tx_cnt_q;
    logic [7:0] rx_sh_q, pos_lo_q;
    logic [9:0] tx_sh_q;
    logic [3:0] rx_bit_q, tx_bit_q;
    logic [2:0] cmd_addr_q;
    logic have_cmd_q, rx_done_q;
    logic tick, step_fall, close_ovr, open_ovr, step_req, step_dir, move;
    logic [7:0] rd_data;

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    // reset to high so a released or floating pin makes no edge
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            step_s1_q <= 1'b1;
            step_s2_q <= 1'b1;
            step_s3_q <= 1'b1;
            dir_s1_q <= DIR_OPEN;
            dir_s2_q <= DIR_OPEN;
        end
        else
        begin
            step_s1_q <= link.step_n;
            step_s2_q <= step_s1_q;
            step_s3_q <= step_s2_q;
            dir_s1_q <= link.dir; // dir delayed as far as the step edge
            dir_s2_q <= dir_s1_q;
        end
    end

    assign step_fall = step_s3_q & ~step_s2_q;
    assign close_ovr = ~link.close_n;
    assign open_ovr = ~link.full_open_override_n & ~close_ovr;

    // ------------------------------------------------------------
    // power-up close and override step rate
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_POWERUP;
            pwr_cnt_q <= 32'h0;
        end
        else if (state_q == ST_POWERUP)
        begin
            pwr_cnt_q <= pwr_cnt_q + 32'h1;
            if (pwr_cnt_q == 32'(POWERUP_CYC - 1))
                state_q <= ST_RUN;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i || tick)
            tick_cnt_q <= 16'h0;
        else
            tick_cnt_q <= tick_cnt_q + 16'h1;
    end
    assign tick = tick_cnt_q == 16'(OVR_STEP_CYC - 1);

    // ------------------------------------------------------------
    // step source selection
    // ------------------------------------------------------------
    always_comb
    begin
        step_req = 1'b0;
        step_dir = DIR_CLOSE;
        unique case (state_q)
            ST_POWERUP:
            begin
                step_req = tick;
                step_dir = DIR_CLOSE;
            end
            ST_RUN:
            begin
                if (close_ovr)
                begin
                    step_req = tick;
                    step_dir = DIR_CLOSE;
                end
                else if (open_ovr)
                begin
                    step_req = tick;
                    step_dir = DIR_OPEN;
                end
                else if (mode_q == MODE_STEP_DIR)
                begin
                    step_req = step_fall;
                    step_dir = dir_s2_q;
                end
            end
        endcase
    end

    // the needle stops at its mechanical ends
    assign move = step_req & ((step_dir == DIR_OPEN) ? (pos_q != 16'(FULL_OPEN_STEPS)) : (pos_q != 16'h0));

    // ------------------------------------------------------------
    // position and motor outputs
    // ------------------------------------------------------------
    // reset assumes fully open so the power-up close runs the full travel
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            pos_q <= 16'(FULL_OPEN_STEPS);
        else if (state_q == ST_POWERUP && pwr_cnt_q == 32'(POWERUP_CYC - 1))
            pos_q <= 16'h0;
        else if (move)
            pos_q <= (step_dir == DIR_OPEN) ? pos_q + 16'h1 : pos_q - 16'h1;
        else if (rx_done_q && have_cmd_q && cmd_addr_q == SREG_POS_HI)
            pos_q <= {rx_sh_q, pos_lo_q};
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            motor_step_o <= 1'b0;
            motor_dir_o <= DIR_CLOSE;
            motor_enable_o <= 1'b0;
            led_green_o <= 1'b0;
            led_red_o <= 1'b0;
        end
        else
        begin
            motor_step_o <= move;
            if (step_req)
                motor_dir_o <= step_dir;
            // coil off when idle; the lead screw holds the needle
            motor_enable_o <= move || state_q == ST_POWERUP || close_ovr || open_ovr;
            led_green_o <= state_q == ST_RUN && close_ovr && pos_q == 16'h0;
            led_red_o <= state_q == ST_RUN && open_ovr && pos_q == 16'(FULL_OPEN_STEPS);
        end
    end
    assign position_o = pos_q;
    assign mode_o = mode_q;

    // ------------------------------------------------------------
    // serial receiver, 8N1
    // ------------------------------------------------------------
    // receiver deaf while we talk, so no echo is taken as a command
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rx_q <= RX_IDLE;
            rx_cnt_q <= 16'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h0;
            rx_done_q <= 1'b0;
        end
        else
        begin
            rx_done_q <= 1'b0;
            rx_cnt_q <= rx_cnt_q + 16'h1;
            unique case (rx_q)
                RX_IDLE:
                begin
                    rx_cnt_q <= 16'h0;
                    if (!link.line && tx_q == TX_IDLE)
                        rx_q <= RX_START;
                end
                RX_START:
                    if (rx_cnt_q == 16'(HALF_BAUD_CYC - 1))
                    begin
                        rx_cnt_q <= 16'h0;
                        rx_bit_q <= 4'h0;
                        rx_q <= link.line ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_cnt_q == 16'(BAUD_CYC - 1))
                    begin
                        rx_cnt_q <= 16'h0;
                        rx_sh_q <= {link.line, rx_sh_q[7:1]};
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'h7)
                            rx_q <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_cnt_q == 16'(BAUD_CYC - 1))
                    begin
                        rx_done_q <= link.line; // a frame with a low stop bit is dropped
                        rx_q <= RX_IDLE;
                    end
                default:
                    rx_q <= RX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // command decode: write is two bytes, read answers one
    // ------------------------------------------------------------
    always_comb
    begin
        unique case (cmd_addr_q)
            SREG_MODE: rd_data = {6'h0, mode_q};
            SREG_POS_LO: rd_data = pos_q[7:0];
            SREG_POS_HI: rd_data = pos_q[15:8];
            SREG_STATUS: rd_data = {5'h0, state_q == ST_POWERUP, open_ovr, close_ovr};
            default: rd_data = 8'h0;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            have_cmd_q <= 1'b0;
            cmd_addr_q <= 3'h0;
            pos_lo_q <= 8'h0;
        end
        else if (rx_done_q)
        begin
            if (!have_cmd_q)
            begin
                cmd_addr_q <= rx_sh_q[2:0];
                have_cmd_q <= rx_sh_q[CMD_WRITE_BIT];
            end
            else
            begin
                have_cmd_q <= 1'b0;
                if (cmd_addr_q == SREG_POS_LO)
                    pos_lo_q <= rx_sh_q;
            end
        end
    end

    // button is checked first so a button press wins over a serial write in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            mode_q <= MODE_RESET;
        else if (button_set_i)
            mode_q <= vso_mode_t'(button_mode_i);
        else if (rx_done_q && have_cmd_q && cmd_addr_q == SREG_MODE)
            mode_q <= vso_mode_t'(rx_sh_q[1:0]);
    end

    // ------------------------------------------------------------
    // serial transmitter, one bit of turnaround before the reply
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            tx_q <= TX_IDLE;
            tx_cnt_q <= 16'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3ff;
        end
        else
        begin
            tx_cnt_q <= tx_cnt_q + 16'h1;
            unique case (tx_q)
                TX_IDLE:
                begin
                    tx_cnt_q <= 16'h0;
                    tx_bit_q <= 4'h0;
                    if (rx_done_q && !have_cmd_q && !rx_sh_q[CMD_WRITE_BIT])
                        tx_q <= TX_WAIT;
                end
                TX_WAIT:
                    if (tx_cnt_q == 16'(BAUD_CYC - 1))
                    begin
                        tx_cnt_q <= 16'h0;
                        tx_sh_q <= {1'b1, rd_data, 1'b0};
                        tx_q <= TX_SEND;
                    end
                TX_SEND:
                    if (tx_cnt_q == 16'(BAUD_CYC - 1))
                    begin
                        tx_cnt_q <= 16'h0;
                        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == 4'(FRAME_BITS - 1))
                            tx_q <= TX_IDLE;
                    end
                default:
                    tx_q <= TX_IDLE;
            endcase
        end
    end

    assign link.dev_tx = tx_sh_q[0];
    assign link.dev_tx_oe = tx_q == TX_SEND;
endmodule

// >>> design/vso_valve_host.sv
// controller end: apb registers driving step, direction, overrides and the serial link
`timescale 1ns/100ps
module vso_valve_host
    import vso_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    vso_link_if.host link
);
    logic [3:0] ctrl_q;
    logic [15:0] step_cnt_q, tx_cnt_q, rx_cnt_q;
    logic step_busy_q, tx_busy_q, rx_valid_q, rx_on_q;
    logic [9:0] tx_sh_q;
    logic [3:0] tx_bit_q, rx_bit_q;
    logic [7:0] rx_sh_q, rx_data_q;
    logic wr, rd, mapped;

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign mapped = paddr_i == A_CTRL || paddr_i == A_STEP || paddr_i == A_TXDATA
        || paddr_i == A_STATUS || paddr_i == A_RXDATA;
    assign wr = psel_i && penable_i && pwrite_i && mapped;
    assign rd = psel_i && penable_i && !pwrite_i && paddr_i == A_RXDATA;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;

    // read data captured in the setup cycle so it is a flop in the access cycle
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            prdata_o <= 32'h0;
        else if (psel_i && !penable_i)
        begin
            unique case (paddr_i)
                A_CTRL: prdata_o <= {28'h0, ctrl_q};
                A_STATUS: prdata_o <= {29'h0, step_busy_q, rx_valid_q, tx_busy_q};
                A_RXDATA: prdata_o <= {24'h0, rx_data_q};
                default: prdata_o <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            ctrl_q <= CTRL_RESET;
        else if (wr && paddr_i == A_CTRL)
            ctrl_q <= pwdata_i[3:0];
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // with drive off the valve sees its pull-ups on step and dir only
    assign link.step_oe = ctrl_q[CTRL_DRIVE_BIT];
    assign link.dir_oe = ctrl_q[CTRL_DRIVE_BIT];
    assign link.dir_drv = ctrl_q[CTRL_DIR_BIT];
    assign link.close_oe = ctrl_q[CTRL_CLOSE_BIT];
    assign link.open_oe = ctrl_q[CTRL_OPEN_BIT];

    // ------------------------------------------------------------
    // step pulse: low then high, each STEP_LOW_CYC
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            step_busy_q <= 1'b0;
            step_cnt_q <= 16'h0;
        end
        else if (step_busy_q)
        begin
            step_cnt_q <= step_cnt_q + 16'h1;
            if (step_cnt_q == 16'(2 * STEP_LOW_CYC - 1))
                step_busy_q <= 1'b0;
        end
        else if (wr && paddr_i == A_STEP)
        begin
            step_busy_q <= 1'b1;
            step_cnt_q <= 16'h0;
        end
    end
    assign link.step_drv = !(step_busy_q && step_cnt_q < 16'(STEP_LOW_CYC));

    // ------------------------------------------------------------
    // serial transmitter; driver on only for the frame
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            tx_busy_q <= 1'b0;
            tx_cnt_q <= 16'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 10'h3ff;
        end
        else if (!tx_busy_q)
        begin
            if (wr && paddr_i == A_TXDATA && !rx_on_q)
            begin
                tx_busy_q <= 1'b1;
                tx_sh_q <= {1'b1, pwdata_i[7:0], 1'b0};
                tx_cnt_q <= 16'h0;
                tx_bit_q <= 4'h0;
            end
        end
        else if (tx_cnt_q == 16'(BAUD_CYC - 1))
        begin
            tx_cnt_q <= 16'h0;
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'(FRAME_BITS - 1))
                tx_busy_q <= 1'b0;
        end
        else
            tx_cnt_q <= tx_cnt_q + 16'h1;
    end
    assign link.host_tx_line = tx_sh_q[0];
    assign link.host_tx_oe = tx_busy_q;

    // ------------------------------------------------------------
    // serial receiver, gated off while sending to drop the echo
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rx_on_q <= 1'b0;
            rx_cnt_q <= 16'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h0;
        end
        else if (!rx_on_q)
        begin
            rx_cnt_q <= 16'h0;
            rx_bit_q <= 4'h0;
            if (!link.line && !tx_busy_q)
                rx_on_q <= 1'b1;
        end
        else if (rx_cnt_q == 16'((rx_bit_q == 4'h0) ? HALF_BAUD_CYC - 1 : BAUD_CYC - 1))
        begin
            rx_cnt_q <= 16'h0;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h0 && link.line)
                rx_on_q <= 1'b0;
            else if (rx_bit_q == 4'(FRAME_BITS - 1))
                rx_on_q <= 1'b0;
            else if (rx_bit_q != 4'h0)
                rx_sh_q <= {link.line, rx_sh_q[7:1]};
        end
        else
            rx_cnt_q <= rx_cnt_q + 16'h1;
    end

    // new byte wins over a read that clears the flag in the same cycle
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            rx_valid_q <= 1'b0;
            rx_data_q <= 8'h0;
        end
        else if (rx_on_q && rx_bit_q == 4'(FRAME_BITS - 1) && rx_cnt_q == 16'(BAUD_CYC - 1) && link.line)
        begin
            rx_valid_q <= 1'b1;
            rx_data_q <= rx_sh_q;
        end
        else if (rd)
            rx_valid_q <= 1'b0;
    end
endmodule

// >>> tb/tb_valve_step_override_control.sv
// bench joining the controller and the valve over the link
`timescale 1ns/100ps
module tb_valve_step_override_control;
    import vso_pkg::*;
    logic clock_i = 0;
    logic reset_i = 1;
    logic [7:0] pa = 0;
    logic ps = 0, pe = 0, pw = 0, err, rdy, bset = 0, mst, mdir, men, grn, red;
    logic [31:0] pd = 0, prd, r;
    logic [1:0] bmode = 0, mode;
    logic [15:0] pos, p0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int pulses = 0;
    vso_link_if link ();
    vso_valve_host i_vso_valve_host (.clock_i(clock_i), .reset_i(reset_i), .paddr_i(pa), .psel_i(ps),
        .penable_i(pe), .pwrite_i(pw), .pwdata_i(pd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
        .link(link.host));
    // short power-up keeps the run small; position jumps to closed at its end
    vso_valve_dev #(.POWERUP_CYC(2000)) i_vso_valve_dev (.clock_i(clock_i), .reset_i(reset_i),
        .link(link.device), .button_mode_i(bmode), .button_set_i(bset), .motor_step_o(mst),
        .motor_dir_o(mdir), .motor_enable_o(men), .led_green_o(grn), .led_red_o(red), .mode_o(mode),
        .position_o(pos));
    vso_link_checker i_vso_link_checker (.clock_i(clock_i), .reset_i(reset_i), .step_n(link.step_n),
        .host_tx_line(link.host_tx_line), .host_tx_oe(link.host_tx_oe), .dev_tx(link.dev_tx),
        .dev_tx_oe(link.dev_tx_oe));
    initial
    begin
        forever #20 clock_i = ~clock_i;
    end
    always @(posedge clock_i)
        pulses <= pulses + mst;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        ps <= 1;
        pe <= 0;
        pa <= a;
        pw <= w;
        pd <= d;
        @(posedge clock_i);
        pe <= 1;
        do @(posedge clock_i); while (rdy !== 1'b1);
        r = {err, prd[30:0]};
        ps <= 0;
        pe <= 0;
        @(posedge clock_i);
    endtask
    task automatic wait_stat(input int b, input logic v, input int n);
        repeat (n)
        begin
            apb(0, A_STATUS, 0);
            if (r[b] === v)
                break;
        end
        if (r[b] !== v)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t status bit %0d never reached", $time, b);
        end
    endtask
    task automatic step_once();
        apb(1, A_STEP, 0);
        wait_stat(STAT_STEP_BUSY_BIT, 0, 40);
    endtask
    task automatic set_mode(input logic [1:0] m);
        bmode <= m;
        bset <= 1;
        @(posedge clock_i);
        bset <= 0;
        @(posedge clock_i);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_powerup();
        repeat (4) @(posedge clock_i);
        chk({men, pos}, {1'b1, 16'(FULL_OPEN_STEPS)});
        repeat (2100) @(posedge clock_i);
        chk({men, mode, pos}, {1'b0, 2'h3, 16'h0});
    endtask
    task automatic t_steps();
        int c0;
        // the power-up close has already issued one motor pulse of its own
        c0 = pulses;
        apb(1, A_CTRL, 32'h9);
        repeat (3) step_once();
        chk({mdir, pos}, {DIR_OPEN, 16'h3});
        apb(1, A_CTRL, 32'h8);
        step_once();
        chk({mdir, pos}, {DIR_CLOSE, 16'h2});
        chk(pulses - c0, 32'h4);
    endtask
    task automatic t_gate();
        set_mode(2'h1);
        step_once();
        chk({mode, pos}, {2'h1, 16'h2});
    endtask
    task automatic t_serial();
        apb(1, A_TXDATA, 32'h0);
        wait_stat(STAT_RX_VALID_BIT, 1, 30000);
        apb(0, A_RXDATA, 0);
        chk(r, 32'h1);
        apb(0, 8'h20, 0);
        chk(r, 32'h8000_0000);
        set_mode(2'h3);
    endtask
    task automatic t_override();
        apb(1, A_CTRL, 32'he);
        repeat (2 * OVR_STEP_CYC + 200) @(posedge clock_i);
        chk({pos, grn, red}, {16'h0, 2'b10});
        step_once();
        chk(pos, 32'h0);
        apb(1, A_CTRL, 32'hc);
        repeat (OVR_STEP_CYC + 200) @(posedge clock_i);
        chk({red, mdir, pos != 0}, 3'b011);
        apb(1, A_CTRL, 32'h8);
        repeat (10) @(posedge clock_i);
        p0 = pos;
        repeat (3000) @(posedge clock_i);
        chk({men, pos}, {1'b0, p0});
        apb(1, A_CTRL, 32'h0);
        step_once();
        chk(pos, p0);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_i <= 0;
        t_powerup();
        t_steps();
        t_gate();
        t_serial();
        t_override();
        report_and_stop();
    end
    // whole run is near 65k cycles; 95k means a hang
    initial
    begin
        repeat (95000) @(posedge clock_i);
        n_mismatch++;
        report_and_stop();
    end
endmodule

// >>> tb/vso_link_checker.sv
// protocol checks on the link between controller and valve
`timescale 1ns/100ps
module vso_link_checker
    import vso_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic step_n,
    input wire logic host_tx_line,
    input wire logic host_tx_oe,
    input wire logic dev_tx,
    input wire logic dev_tx_oe
);
    localparam int FR = FRAME_BITS * BAUD_CYC;
    int hc_q;
    int dc_q;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // cycles spent inside the current frame of each talker
    always_ff @(posedge clock_i)
    begin
        hc_q <= (reset_i || !host_tx_oe) ? 0 : hc_q + 1;
        dc_q <= (reset_i || !dev_tx_oe) ? 0 : dc_q + 1;
    end
    one_talker_a: assert property (!(host_tx_oe && dev_tx_oe)) else $error("both ends drive");
    host_frame_a: assert property ($fell(host_tx_oe) |-> hc_q == FR) else $error("host frame length");
    dev_frame_a: assert property ($fell(dev_tx_oe) |-> dc_q == FR) else $error("valve frame length");
    host_start_a: assert property (host_tx_oe && hc_q < BAUD_CYC |-> !host_tx_line) else $error("start");
    host_stop_a: assert property (host_tx_oe && hc_q >= FR - BAUD_CYC |-> host_tx_line) else $error("stop");
    dev_start_a: assert property (dev_tx_oe && dc_q < BAUD_CYC |-> !dev_tx) else $error("valve start");
    bit_stable_a: assert property (host_tx_oe && hc_q % BAUD_CYC != 0 |-> $stable(host_tx_line))
        else $error("bit changed mid period");
    answer_gap_a: assert property ($fell(host_tx_oe) |-> !dev_tx_oe [*8]) else $error("answer too early");
    step_low_a: assert property ($fell(step_n) |-> ##24 !step_n ##1 step_n) else $error("step width");
endmodule
